// >>> core/tpwm_channel.sv
// one output compare / pwm channel
`timescale 1ns/1ps
module tpwm_channel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic wrap,
    input wire tpwm_pkg::tpwm_count_t next_cnt,
    input wire tpwm_pkg::tpwm_count_t cmp,
    input wire logic enable,
    input wire tpwm_pkg::tpwm_action_e action,
    input wire logic tov,
    input wire logic full,
    output logic level,
    output logic hit
);
    import tpwm_pkg::*;
    logic forcing;

    // exact match only: a value already passed is missed this period
    assign hit = enable && tick && (next_cnt == cmp);
    assign forcing = (action == tpwm_act_clear) || (action == tpwm_act_set);

    // compare wins over a wrap toggle in the same tick, so cmp 0 is 0%
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= 1'b0;
        end else if (enable && tick) begin
            if (full && tov && forcing) begin
                level <= ~action[0];
            end else if (hit) begin
                case (action)
                    tpwm_act_toggle: level <= ~level;
                    tpwm_act_clear: level <= 1'b0;
                    tpwm_act_set: level <= 1'b1;
                    default: level <= level;
                endcase
            end else if (wrap && tov) begin
                level <= ~level;
            end
        end
    end

    full_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable && tick && full && tov && action == tpwm_act_clear)
        |=> level) else $error("full duty output not at pulse level");
    zero_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable && !tov && action == tpwm_act_clear && hit)
        ##1 (enable && !tov && action == tpwm_act_clear)[*2] |-> !level)
        else $error("zero duty output left its forced state");
endmodule : tpwm_channel

// >>> core/tpwm_consts.svh
// register offsets, field positions and reset values of the pwm timer
// Summary of operation
// - each channel makes unbuffered pwm; width set by its own compare value.
// - rewriting an unbuffered compare unsynchronised may corrupt up to two periods.
// - pair 0/1 link bit makes one buffered pwm on channel 0 pin.
// - partner write takes over next period; last written set rules at wraps.
// - pairs 2/3 and 4/5 link likewise, output on the even pin.
// - linked pair: odd control unused, even controls, odd pin released.
// - buffered select beats unbuffered select on even channels.
// - toggle on wrap clear gives a 0% duty output.
// - full duty bit plus toggle on wrap gives 100% duty.
// - wrap flag set at period limit; interrupt only while enabled.
// - channel flags set on compare; interrupt only while enabled.
// - wait mode: timer runs, bus refused, enabled interrupt wakes.
// - stop mode: timer frozen, registers and counter kept.
// - with toggle on wrap set, pwm output toggles on the tick that takes the counter from the period limit back to zero.
// - at the period limit set wrap flag, restart from zero next tick.
// - counter reset bit clears counter and prescaler, reads zero.
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH
`define TPWM_OFS_CTRL 8'h00
`define TPWM_OFS_COUNT 8'h04
`define TPWM_OFS_PERIOD 8'h08
`define TPWM_OFS_HOLE 8'h0c
`define TPWM_OFS_CHAN0 8'h10
`define TPWM_CHAN_STRIDE 8'h08
`define TPWM_CMP_OFS 8'h04
`define TPWM_OFS_LAST 8'h3c
`define TPWM_CTL_FLAG 7
`define TPWM_CTL_IRQEN 6
`define TPWM_CTL_HALT 5
`define TPWM_CTL_RST 4
`define TPWM_CH_FLAG 7
`define TPWM_CH_IRQEN 6
`define TPWM_CH_BUF 5
`define TPWM_CH_UNBUF 4
`define TPWM_CH_ACTHI 3
`define TPWM_CH_ACTLO 2
`define TPWM_CH_TOV 1
`define TPWM_CH_FULL 0
`define TPWM_HALT_RST 1'b1
`define TPWM_PERIOD_RST 16'hffff
`define TPWM_CHAN_RST 8'h00
`define TPWM_PS_EXT 3'h7
`define TPWM_RESP_OKAY 2'h0
`define TPWM_RESP_SLVERR 2'h2
`endif

// >>> core/tpwm_pkg.sv
// types shared by the pwm timer modules
package tpwm_pkg;
    typedef logic [7:0] tpwm_addr_t;
    typedef logic [31:0] tpwm_word_t;
    typedef logic [15:0] tpwm_count_t;
    typedef enum logic [1:0] {
        tpwm_act_off = 2'h0,
        tpwm_act_toggle = 2'h1,
        tpwm_act_clear = 2'h2,
        tpwm_act_set = 2'h3
    } tpwm_action_e;
endpackage : tpwm_pkg

// >>> core/tpwm_prescaler.sv
// clock prescaler giving the counter tick
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module tpwm_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [5:0] div;
    logic [5:0] mask;

    // external clock select is not modelled, so that code yields no tick
    assign mask = 6'((7'h01 << sel) - 7'h01);
    assign tick = run && !clear && (sel != `TPWM_PS_EXT)
        && ((div & mask) == mask);

    // divider clears with the counter reset bit
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            div <= 6'h00;
        end else if (run) begin
            div <= div + 6'h01;
        end
    end
endmodule : tpwm_prescaler

// >>> core/tpwm_top.sv
// six channel pwm timer with axi4-lite register slave
`timescale 1ns/1ps
`include "tpwm_consts.svh"
module tpwm_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic awvalid,
    output logic awready,
    input wire tpwm_pkg::tpwm_addr_t awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire tpwm_pkg::tpwm_word_t wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire tpwm_pkg::tpwm_addr_t araddr,
    output logic rvalid,
    input wire logic rready,
    output tpwm_pkg::tpwm_word_t rdata,
    output logic [1:0] rresp,
    output logic [5:0] chan_pin_out,
    output logic [5:0] chan_pin_oe,
    output logic irq
);
    import tpwm_pkg::*;

    logic aw_held, w_held, do_write, aw_fire, w_fire, ar_fire;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    tpwm_addr_t aw_addr_q;
    tpwm_word_t wdata_q, rd_word, ctrl_mw, period_mw;
    logic [3:0] wstrb_q;
    logic wr_ok, rd_ok, wr_ctrl, wr_period, rd_ctrl;
    logic wflag, wien, halt, wflag_arm, tick, wrap, clr, run;
    logic [2:0] ps;
    logic [7:0] ctrl_byte;
    tpwm_count_t cnt, period, next_cnt;
    logic [7:0] chan_ctl [0:5];
    tpwm_count_t chan_cmp [0:5];
    tpwm_count_t chan_sel_cmp [0:5];
    tpwm_word_t chan_ctl_mw [0:5];
    tpwm_word_t chan_cmp_mw [0:5];
    logic [7:0] chan_rd [0:5];
    logic [5:0] chan_flag, chan_arm, chan_hit, chan_level, chan_en;
    logic [5:0] wr_ctl, wr_cmp, rd_chan, chan_irq_src;
    logic [2:0] pair_last, pair_act, link;

    function automatic logic addr_ok(input tpwm_addr_t a);
        addr_ok = (a[1:0] == 2'h0) && (a <= `TPWM_OFS_LAST)
            && (a != `TPWM_OFS_HOLE);
    endfunction : addr_ok

    // byte lane merge so partial writes keep untouched fields
    function automatic tpwm_word_t merge(input tpwm_word_t old,
        input tpwm_word_t d, input logic [3:0] s);
        tpwm_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // bus handshakes: one write and one read in flight, answers registered
    assign aw_fire = awvalid && awready;
    assign w_fire = wvalid && wready;
    assign ar_fire = arvalid && arready;
    assign do_write = aw_held && w_held && !bvalid;
    assign next_aw_held = (aw_held || aw_fire) && !do_write;
    assign next_w_held = (w_held || w_fire) && !do_write;
    assign next_bvalid = do_write || (bvalid && !bready);
    assign next_rvalid = ar_fire || (rvalid && !rready);

    // write channels and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bresp <= `TPWM_RESP_OKAY;
            aw_addr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            bvalid <= next_bvalid;
            awready <= !next_aw_held && !next_bvalid;
            wready <= !next_w_held && !next_bvalid;
            if (aw_fire) begin
                aw_addr_q <= awaddr;
            end
            if (w_fire) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_write) begin
                // the cpu cannot reach the registers in wait mode
                bresp <= (wait_mode || !addr_ok(aw_addr_q)) ?
                    `TPWM_RESP_SLVERR : `TPWM_RESP_OKAY;
            end
        end
    end

    // read channel; data captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            arready <= 1'b0;
            rdata <= 32'h0;
            rresp <= `TPWM_RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            arready <= !next_rvalid;
            if (ar_fire) begin
                rdata <= rd_ok ? rd_word : 32'h0;
                rresp <= rd_ok ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
            end
        end
    end

    // decode of the accepted requests
    assign wr_ok = do_write && !wait_mode && addr_ok(aw_addr_q);
    assign rd_ok = !wait_mode && addr_ok(araddr);
    assign wr_ctrl = wr_ok && (aw_addr_q == `TPWM_OFS_CTRL);
    assign wr_period = wr_ok && (aw_addr_q == `TPWM_OFS_PERIOD);
    assign rd_ctrl = ar_fire && rd_ok && (araddr == `TPWM_OFS_CTRL);

    // reset bit always reads as zero
    assign ctrl_byte = {wflag, wien, halt, 2'h0, ps};
    assign ctrl_mw = merge({24'h0, ctrl_byte}, wdata_q, wstrb_q);
    assign period_mw = merge({16'h0, period}, wdata_q, wstrb_q);
    assign clr = wr_ctrl && ctrl_mw[`TPWM_CTL_RST];

    // read mux
    always_comb begin
        rd_word = 32'h0;
        case (araddr)
            `TPWM_OFS_CTRL: rd_word = {24'h0, ctrl_byte};
            `TPWM_OFS_COUNT: rd_word = {16'h0, cnt};
            `TPWM_OFS_PERIOD: rd_word = {16'h0, period};
            default: begin
                for (int i = 0; i < 6; i++) begin
                    if (araddr == 8'(`TPWM_OFS_CHAN0
                        + i * `TPWM_CHAN_STRIDE)) begin
                        rd_word = {24'h0, chan_rd[i]};
                    end
                    if (araddr == 8'(`TPWM_OFS_CHAN0 + `TPWM_CMP_OFS
                        + i * `TPWM_CHAN_STRIDE)) begin
                        rd_word = {16'h0, chan_cmp[i]};
                    end
                end
            end
        endcase
    end

    // timer control fields; halt is set out of reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wien <= 1'b0;
            halt <= `TPWM_HALT_RST;
            ps <= 3'h0;
        end else if (wr_ctrl) begin
            wien <= ctrl_mw[`TPWM_CTL_IRQEN];
            halt <= ctrl_mw[`TPWM_CTL_HALT];
            ps <= ctrl_mw[2:0];
        end
    end

    // wrap flag: clear needs a read while set, then a zero write;
    // a wrap in between disarms, and a wrap beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wflag <= 1'b0;
            wflag_arm <= 1'b0;
        end else begin
            if (wrap) begin
                wflag <= 1'b1;
            end else if (wr_ctrl && wflag_arm
                && !ctrl_mw[`TPWM_CTL_FLAG]) begin
                wflag <= 1'b0;
            end
            if (wrap || wr_ctrl) begin
                wflag_arm <= 1'b0;
            end else if (rd_ctrl && wflag) begin
                wflag_arm <= 1'b1;
            end
        end
    end

    // period limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period <= `TPWM_PERIOD_RST;
        end else if (wr_period) begin
            period <= period_mw[15:0];
        end
    end

    // stop mode freezes the whole timer; wait mode does not
    assign run = !halt && !stop_mode;

    tpwm_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(run),
        .clear(clr),
        .sel(ps),
        .tick(tick)
    );

    assign wrap = tick && (cnt == period);
    assign next_cnt = (cnt == period) ? 16'h0 : cnt + 16'h1;

    // counter advances per tick and restarts from zero after the limit
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            cnt <= 16'h0;
        end else if (tick) begin
            cnt <= next_cnt;
        end
    end

    // channel registers, flags and the compare engines
    for (genvar k = 0; k < 6; k++) begin : g_chan
        localparam tpwm_addr_t CTL_A = 8'(`TPWM_OFS_CHAN0
            + k * `TPWM_CHAN_STRIDE);
        localparam tpwm_addr_t CMP_A = 8'(CTL_A + `TPWM_CMP_OFS);

        assign wr_ctl[k] = wr_ok && (aw_addr_q == CTL_A);
        assign wr_cmp[k] = wr_ok && (aw_addr_q == CMP_A);
        assign rd_chan[k] = ar_fire && rd_ok && (araddr == CTL_A);
        assign chan_rd[k] = {chan_flag[k], chan_ctl[k][6:0]};
        assign chan_ctl_mw[k] = merge({24'h0, chan_rd[k]}, wdata_q,
            wstrb_q);
        assign chan_cmp_mw[k] = merge({16'h0, chan_cmp[k]}, wdata_q,
            wstrb_q);
        assign chan_irq_src[k] = chan_flag[k]
            && chan_ctl[k][`TPWM_CH_IRQEN];

        // writes to an active compare act at once, as unbuffered
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                chan_ctl[k] <= `TPWM_CHAN_RST;
                chan_cmp[k] <= 16'h0;
            end else begin
                if (wr_ctl[k]) begin
                    chan_ctl[k] <= chan_ctl_mw[k][7:0];
                end
                if (wr_cmp[k]) begin
                    chan_cmp[k] <= chan_cmp_mw[k][15:0];
                end
            end
        end

        // channel flag with the same two step clear as the wrap flag
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                chan_flag[k] <= 1'b0;
                chan_arm[k] <= 1'b0;
            end else begin
                if (chan_hit[k]) begin
                    chan_flag[k] <= 1'b1;
                end else if (wr_ctl[k] && chan_arm[k]
                    && !chan_ctl_mw[k][`TPWM_CH_FLAG]) begin
                    chan_flag[k] <= 1'b0;
                end
                if (chan_hit[k] || wr_ctl[k]) begin
                    chan_arm[k] <= 1'b0;
                end else if (rd_chan[k] && chan_flag[k]) begin
                    chan_arm[k] <= 1'b1;
                end
            end
        end

        if (k % 2 == 0) begin : g_even
            // buffered select wins over unbuffered and links the pair
            assign link[k/2] = chan_ctl[k][`TPWM_CH_BUF];
            assign chan_en[k] = chan_ctl[k][`TPWM_CH_BUF]
                || chan_ctl[k][`TPWM_CH_UNBUF];
            assign chan_sel_cmp[k] = (link[k/2] && pair_act[k/2]) ?
                chan_cmp[k+1] : chan_cmp[k];
        end else begin : g_odd
            // odd channel is idle and its pin released while linked
            assign chan_en[k] = chan_ctl[k][`TPWM_CH_UNBUF]
                && !link[k/2];
            assign chan_sel_cmp[k] = chan_cmp[k];
        end

        tpwm_channel u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick),
            .wrap(wrap),
            .next_cnt(next_cnt),
            .cmp(chan_sel_cmp[k]),
            .enable(chan_en[k]),
            .action(tpwm_action_e'(chan_ctl[k][3:2])),
            .tov(chan_ctl[k][`TPWM_CH_TOV]),
            .full(chan_ctl[k][`TPWM_CH_FULL]),
            .level(chan_level[k]),
            .hit(chan_hit[k])
        );

        // pins registered; undriven when idle so the port can take it
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                chan_pin_out[k] <= 1'b0;
                chan_pin_oe[k] <= 1'b0;
            end else begin
                chan_pin_out[k] <= chan_level[k];
                chan_pin_oe[k] <= chan_en[k]
                    && (chan_ctl[k][3:2] != 2'h0);
            end
        end
    end

    // pair handover: the last written set takes control at each wrap
    for (genvar p = 0; p < 3; p++) begin : g_pair
        always_ff @(posedge aclk) begin
            if (!aresetn || !link[p]) begin
                pair_last[p] <= 1'b0;
                pair_act[p] <= 1'b0;
            end else begin
                if (wr_cmp[2*p+1]) begin
                    pair_last[p] <= 1'b1;
                end else if (wr_cmp[2*p]) begin
                    pair_last[p] <= 1'b0;
                end
                if (wrap) begin
                    pair_act[p] <= pair_last[p];
                end
            end
        end
    end

    // one request line; it also wakes the system from wait mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (wflag && wien) || (|chan_irq_src);
        end
    end

    wrap_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap |=> wflag ##1
        (irq == ($past(wien) || $past(|chan_irq_src))))
        else $error("wrap did not set the flag or request");
    cnt_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wrap && !clr) |=> (cnt == 16'h0))
        else $error("counter did not restart after the limit");
    halt_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (halt && !clr) |=> $stable(cnt))
        else $error("counter moved while halted");
    counter_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clr |=> (cnt == 16'h0) && (ctrl_byte[`TPWM_CTL_RST] == 1'b0))
        else $error("counter reset did not clear the counter");
    stop_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_mode && !clr) |=> $stable(cnt) && $stable(wflag))
        else $error("timer changed in stop mode");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!(wflag && wien) && chan_irq_src == 6'h0) |=> !irq)
        else $error("interrupt raised with nothing enabled");
    pair_handover_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (link[0] && wrap && pair_last[0]) ##1 link[0] |-> pair_act[0])
        else $error("pair did not hand over at the wrap");
    odd_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        link[0] [*2] |-> !chan_pin_oe[1])
        else $error("odd pin driven while pair is linked");
    wait_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && wait_mode) |=> bvalid && bresp == `TPWM_RESP_SLVERR)
        else $error("write accepted in wait mode");
endmodule : tpwm_top

// >>> testbench/tb.sv
// self-checking bench for the pwm timer
`timescale 1ns/1ps
module tb;
    import tpwm_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, clr = 1'h0;
    logic wait_mode = 1'h0, stop_mode = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    tpwm_addr_t awaddr = '0, araddr = '0;
    tpwm_word_t wdata = '0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [5:0] pin_out, pin_oe, pin_lvl;
    logic [5:0][15:0] hi_cnt;
    logic [1:0] wq[$], rq_r[$];
    tpwm_word_t rq_d[$];
    logic [15:0] cmp_v[6], exp_hi[6];
    int mismatches = 0, comparisons = 0, cyc = 0;
    always #2 aclk = ~aclk;
    tpwm_top dut_u (.aclk, .aresetn, .wait_mode, .stop_mode, .awvalid,
        .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
        .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
        .rdata, .rresp, .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
        .irq);
    tpwm_load load_u (.aclk, .clr, .pin_out, .pin_oe, .pin_lvl, .hi_cnt);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    // write: offer address and data together, release each when taken
    task automatic wr(input tpwm_addr_t a, input tpwm_word_t d,
            input logic [1:0] r = 2'h0);
        logic a_ok, w_ok, b_ok;
        wq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b_ok = 1'h0;
        // loop on a local flag: the nba above is not yet visible here
        while (!b_ok) begin
            @(negedge aclk);
            a_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid & bready;
            @(posedge aclk);
            if (a_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
            if (b_ok) bready <= 1'h0;
        end
        // let an edge pass so a following call never re-raises bready
        @(posedge aclk);
    endtask : wr
    task automatic rd(input tpwm_addr_t a, input tpwm_word_t d,
            input logic [1:0] r = 2'h0);
        logic a_ok, r_ok;
        rq_d.push_back(d);
        rq_r.push_back(r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r_ok = 1'h0;
        while (!r_ok) begin
            @(negedge aclk);
            a_ok = arvalid & arready;
            r_ok = rvalid & rready;
            @(posedge aclk);
            if (a_ok) arvalid <= 1'h0;
            if (r_ok) rready <= 1'h0;
        end
        // one idle edge before rready may rise again
        @(posedge aclk);
    endtask : rd
    // settle two periods, then count high time over four periods
    task automatic meas(input logic [5:0] m);
        repeat (20) @(posedge aclk);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
        repeat (40) @(posedge aclk);
        @(negedge aclk);
        for (int i = 0; i < 6; i++) begin
            if (m[i]) chk(32'(hi_cnt[i]), 32'(exp_hi[i]));
        end
        @(posedge aclk);
    endtask : meas
    task automatic irq_is(input logic v);
        @(negedge aclk);
        chk(32'(irq), 32'(v));
        @(posedge aclk);
    endtask : irq_is
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // responses are compared with the oldest note, in issue order
    always @(negedge aclk) begin
        if ((bvalid & bready) === 1'h1) chk(32'(bresp), 32'(wq.pop_front()));
        if ((rvalid & rready) === 1'h1) begin
            chk(32'(rresp), 32'(rq_r.pop_front()));
            chk(rdata, rq_d.pop_front());
        end
    end
    // cut a hang short; the run needs under 3000 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(32'ha289));
        foreach (cmp_v[i]) cmp_v[i] = 16'($urandom_range(9, 1));
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h00, 32'h20);
        rd(8'h08, 32'hffff);
        rd(8'h10, 32'h0);
        rd(8'h0c, 32'h0, 2'h2);
        done("reset");
        wr(8'h00, 32'h30);
        wr(8'h08, 32'h9);
        for (int i = 0; i < 6; i++) begin
            wr(8'h14 + 8'(8 * i), 32'(cmp_v[i]));
            wr(8'h10 + 8'(8 * i), i[0] ? 32'h1e : 32'h1a);
            exp_hi[i] = 16'h4 * cmp_v[i];
            if (i[0]) exp_hi[i] = 16'h28 - exp_hi[i];
        end
        wr(8'h00, 32'h0);
        meas(6'h3f);
        done("unbuffered");
        wr(8'h10, 32'h18);
        wr(8'h18, 32'h1b);
        exp_hi[0] = 16'h0;
        exp_hi[1] = 16'h28;
        meas(6'h03);
        done("duty limits");
        for (int p = 0; p < 6; p += 2) begin
            wr(8'h14 + 8'(8 * p), 32'h3);
            wr(8'h10 + 8'(8 * p), 32'h3a);
            exp_hi[p] = 16'hc;
            exp_hi[p + 1] = 16'h0;
            meas(6'h3 << p);
            wr(8'h1c + 8'(8 * p), 32'h7);
            exp_hi[p] = 16'h1c;
            meas(6'h1 << p);
        end
        done("buffered");
        wr(8'h00, 32'h40);
        repeat (12) @(posedge aclk);
        irq_is(1'h1);
        rd(8'h10, 32'hba);
        wr(8'h00, 32'h60);
        rd(8'h00, 32'he0);
        wr(8'h00, 32'h60);
        rd(8'h00, 32'h60);
        irq_is(1'h0);
        wr(8'h00, 32'h30);
        rd(8'h00, 32'h20);
        rd(8'h04, 32'h0);
        stop_mode <= 1'h1;
        wr(8'h00, 32'h0);
        repeat (20) @(posedge aclk);
        rd(8'h04, 32'h0);
        stop_mode <= 1'h0;
        wait_mode <= 1'h1;
        rd(8'h00, 32'h0, 2'h2);
        wr(8'h00, 32'h20, 2'h2);
        wait_mode <= 1'h0;
        repeat (20) @(posedge aclk);
        rd(8'h00, 32'h80);
        done("flags and modes");
        report_and_stop;
    end
endmodule : tb

// >>> testbench/tpwm_load.sv
// pin load model: pull-down on every pin, high-time counters
`timescale 1ns/1ps
module tpwm_load (
    input wire logic aclk,
    input wire logic clr,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output logic [5:0] pin_lvl,
    output logic [5:0][15:0] hi_cnt
);
    // a released pin falls to the pull-down, never keeps its level
    assign pin_lvl = pin_out & pin_oe;
    // high time per pin, only meaningful over whole periods
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 6; i++) begin
            hi_cnt[i] <= clr ? 16'h0 : hi_cnt[i] + 16'(pin_lvl[i]);
        end
    end
endmodule : tpwm_load
